// *** verilog/evt_timer.sv ***
// Top of one 8-bit timer/event channel with an AXI4-Lite slave.
// Assumes event and sub-clock pins are asynchronous to clk_i.
//
// Chosen here: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module evt_timer
  import evt_timer_pkg::*;
#(
  parameter int CHANNEL = 0
)
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  // AXI4-Lite write address
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [3:0]  s_axi_awaddr,
  // AXI4-Lite write data
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // AXI4-Lite write response
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic     [1:0]   s_axi_bresp,
  // AXI4-Lite read address
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [3:0]  s_axi_araddr,
  // AXI4-Lite read data
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic     [31:0]  s_axi_rdata,
  output logic     [1:0]   s_axi_rresp,
  // Pins
  input  wire logic        event_input_pin_i,
  input  wire logic        sub_clock_i,
  output logic             wave_output_pin_o,
  output logic             match_irq_o
);

  // -------------------------------------------------------------
  // Register state
  // -------------------------------------------------------------
  logic [7:0]    mode_ctrl_q;
  logic [7:0]    compare_q;
  timer_status_t status_q;
  logic          aw_full_q;
  logic [3:0]    aw_addr_q;
  logic          w_full_q;
  logic [31:0]   w_data_q;
  logic          w_strb0_q;
  logic          bvalid_q;
  logic [1:0]    bresp_q;
  logic          rvalid_q;
  logic [31:0]   rdata_q;
  logic [1:0]    rresp_q;

  logic [7:0]    count;
  logic          match;
  logic          wave;
  logic          do_write;
  logic          tick;

  // Prescaler and pin synchronisers
  logic [7:0]    presc_q;
  logic          ev_meta_q;
  logic          ev_sync_q;
  logic          ev_prev_q;
  logic          sub_meta_q;
  logic          sub_sync_q;
  logic          sub_prev_q;

  // -------------------------------------------------------------
  // Helpers
  // -------------------------------------------------------------
  // Tap true once every div cycles of the free prescaler
  function automatic logic tap(input logic [7:0] p, input int div);
    logic [7:0] mask;
    mask = 8'(div - 1);
    return (p & mask) == mask;
  endfunction

  // Edge of the requested polarity between two sampled levels
  function automatic logic edge_hit(input logic prev, input logic cur,
                                    input logic falling);
    return falling ? (prev && !cur) : (!prev && cur);
  endfunction

  // -------------------------------------------------------------
  // Pin synchronisers and prescaler
  // -------------------------------------------------------------
  // Two flops before any logic reads a pin
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      ev_meta_q  <= 1'b0;
      ev_sync_q  <= 1'b0;
      ev_prev_q  <= 1'b0;
      sub_meta_q <= 1'b0;
      sub_sync_q <= 1'b0;
      sub_prev_q <= 1'b0;
    end
    else
    begin
      ev_meta_q  <= event_input_pin_i;
      ev_sync_q  <= ev_meta_q;
      ev_prev_q  <= ev_sync_q;
      sub_meta_q <= sub_clock_i;
      sub_sync_q <= sub_meta_q;
      sub_prev_q <= sub_sync_q;
    end
  end

  // Free prescaler, held at zero while stopped
  always_ff @(posedge clk_i)
  begin
    if (reset_i || !mode_ctrl_q[RUN_BIT])
      presc_q <= 8'h00;
    else
      presc_q <= presc_q + 8'h01;
  end

  // -------------------------------------------------------------
  // Count clock selection per channel
  // -------------------------------------------------------------
  always_comb
  begin
    logic [1:0] sel;
    sel  = mode_ctrl_q[CLK_SEL_HI:CLK_SEL_LO];
    tick = 1'b0;
    if (CHANNEL == 2)
    begin
      unique case (sel)
        SEL_INT_A: tick = tap(presc_q, CH2_DIV_A);
        SEL_INT_B: tick = tap(presc_q, CH2_DIV_B);
        SEL_EXT_A: tick = edge_hit(sub_prev_q, sub_sync_q, 1'b0);
        default:   tick = 1'b0;
      endcase
    end
    else if (sel[1])
      tick = edge_hit(ev_prev_q, ev_sync_q, mode_ctrl_q[EDGE_SEL_BIT]);
    else if (CHANNEL == 0)
      tick = tap(presc_q, sel[0] ? CH0_DIV_B : CH0_DIV_A);
    else
      tick = tap(presc_q, sel[0] ? CH1_DIV_B : CH1_DIV_A);
  end

  // -------------------------------------------------------------
  // Counter core
  // -------------------------------------------------------------
  evt_timer_core u_core
  (
    .clk_i     (clk_i),
    .reset_i   (reset_i),
    .run_i     (mode_ctrl_q[RUN_BIT]),
    .pwm_i     (mode_ctrl_q[PWM_SEL_BIT]),
    .wave_en_i (mode_ctrl_q[WAVE_EN_BIT]),
    .compare_i (compare_q),
    .tick_i    (tick),
    .count_o   (count),
    .match_o   (match),
    .wave_o    (wave)
  );

  assign wave_output_pin_o = wave;
  assign match_irq_o       = match;

  // -------------------------------------------------------------
  // AXI4-Lite write path
  // -------------------------------------------------------------
  assign s_axi_awready = !aw_full_q && !bvalid_q;
  assign s_axi_wready  = !w_full_q && !bvalid_q;
  assign do_write      = aw_full_q && w_full_q && !bvalid_q;

  // Capture address and data in either order
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      aw_full_q <= 1'b0;
      aw_addr_q <= 4'h0;
      w_full_q  <= 1'b0;
      w_data_q  <= 32'h0000_0000;
      w_strb0_q <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_full_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      else if (do_write)
        aw_full_q <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_full_q  <= 1'b1;
        w_data_q  <= s_axi_wdata;
        w_strb0_q <= s_axi_wstrb[0];
      end
      else if (do_write)
        w_full_q <= 1'b0;
    end
  end

  // Register writes; the count and status words are read only
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      mode_ctrl_q <= MODE_CTRL_RESET;
      compare_q   <= COMPARE_RESET;
    end
    else if (do_write && w_strb0_q)
    begin
      if (aw_addr_q == MODE_CTRL_OFFSET)
        mode_ctrl_q <= w_data_q[7:0];
      if (aw_addr_q == COMPARE_OFFSET)
        compare_q <= w_data_q[7:0];
    end
  end

  // Write response
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end
    else if (do_write)
    begin
      bvalid_q <= 1'b1;
      bresp_q  <= (aw_addr_q == MODE_CTRL_OFFSET || aw_addr_q == COMPARE_OFFSET)
                  ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bready)
      bvalid_q <= 1'b0;
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp  = bresp_q;

  // -------------------------------------------------------------
  // Status and AXI4-Lite read path
  // -------------------------------------------------------------
  // Sticky match flag, set wins over the clear made by reading status
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      status_q <= '0;
    else
    begin
      status_q.wave_level <= wave;
      if (match)
        status_q.match_seen <= 1'b1;
      else if (s_axi_arvalid && s_axi_arready && s_axi_araddr == STATUS_OFFSET)
        status_q.match_seen <= 1'b0;
    end
  end

  assign s_axi_arready = !rvalid_q;

  // Read data registered one cycle after the address
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_q <= 1'b1;
      rresp_q  <= RESP_OKAY;
      unique case (s_axi_araddr)
        MODE_CTRL_OFFSET: rdata_q <= {24'h000000, mode_ctrl_q};
        COMPARE_OFFSET:   rdata_q <= {24'h000000, compare_q};
        COUNT_OFFSET:     rdata_q <= {24'h000000, count};
        STATUS_OFFSET:    rdata_q <= {30'h0, status_q};
        default:
        begin
          rdata_q <= 32'h0000_0000;
          rresp_q <= RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rready)
      rvalid_q <= 1'b0;
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata  = rdata_q;
  assign s_axi_rresp  = rresp_q;

endmodule
`default_nettype wire

// *** pkg/evt_timer_pkg.sv ***
// Package for the 8-bit event timer channel.
// Holds register offsets, control field positions, clock select codes
// and reset values shared by the register slave and the timer core.
package evt_timer_pkg;

  // ---------------------------------------------------------------
  // Register map (byte addresses on the AXI4-Lite slave)
  // ---------------------------------------------------------------
  localparam logic [3:0] MODE_CTRL_OFFSET = 4'h0;
  localparam logic [3:0] COMPARE_OFFSET   = 4'h4;
  localparam logic [3:0] COUNT_OFFSET     = 4'h8;
  localparam logic [3:0] STATUS_OFFSET    = 4'hc;

  // ---------------------------------------------------------------
  // timer_mode_ctrl_reg field positions
  // ---------------------------------------------------------------
  localparam int RUN_BIT       = 7;
  localparam int PWM_SEL_BIT   = 6;
  localparam int CLK_SEL_HI    = 2;
  localparam int CLK_SEL_LO    = 1;
  localparam int EDGE_SEL_BIT  = 1;
  localparam int WAVE_EN_BIT   = 0;

  // ---------------------------------------------------------------
  // Reset values and the counter wrap value
  // ---------------------------------------------------------------
  localparam logic [7:0] MODE_CTRL_RESET = 8'h00;
  localparam logic [7:0] COMPARE_RESET   = 8'h00;
  localparam logic [7:0] COUNT_WRAP      = 8'hff;

  // ---------------------------------------------------------------
  // Count clock select codes (field bits 2:1)
  // ---------------------------------------------------------------
  localparam logic [1:0] SEL_INT_A = 2'h0;
  localparam logic [1:0] SEL_INT_B = 2'h1;
  localparam logic [1:0] SEL_EXT_A = 2'h2;
  localparam logic [1:0] SEL_EXT_B = 2'h3;

  // Prescale divisors in main clock cycles
  localparam int CH0_DIV_A = 1;
  localparam int CH0_DIV_B = 8;
  localparam int CH1_DIV_A = 16;
  localparam int CH1_DIV_B = 256;
  localparam int CH2_DIV_A = 32;
  localparam int CH2_DIV_B = 128;

  // AXI response codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Status flags visible to software
  typedef struct packed {
    logic wave_level;
    logic match_seen;
  } timer_status_t;

endpackage

// *** verilog/evt_timer_core.sv ***
// Counter core of one 8-bit timer channel.
// Assumes tick_i is a one-cycle count-clock pulse already synchronised.
`timescale 1ns/1ps
`default_nettype none
module evt_timer_core
  import evt_timer_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  // Control
  input  wire logic       run_i,
  input  wire logic       pwm_i,
  input  wire logic       wave_en_i,
  input  wire logic [7:0] compare_i,
  input  wire logic       tick_i,
  // Results
  output logic     [7:0]  count_o,
  output logic            match_o,
  output logic            wave_o
);

  logic [7:0] count_q;
  logic       wave_q;
  logic       match_q;
  logic       hit;

  assign hit = tick_i && run_i && (count_q == compare_i);

  // Counter: clear on match in clearing modes, free run in PWM
  always_ff @(posedge clk_i)
  begin
    if (reset_i || !run_i)
      count_q <= 8'h00;
    else if (tick_i)
    begin
      if (hit && !pwm_i)
        count_q <= 8'h00;
      else
        count_q <= count_q + 8'h01;
    end
  end

  // Match pulse in the same cycle the counter clears
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      match_q <= 1'b0;
    else
      match_q <= hit;
  end

  // Wave output: low when stopped or disabled, toggle or PWM otherwise
  always_ff @(posedge clk_i)
  begin
    if (reset_i || !run_i || !wave_en_i)
      wave_q <= 1'b0;
    else if (tick_i)
    begin
      if (pwm_i)
      begin
        if (hit)
          wave_q <= 1'b1;
        else if (count_q == COUNT_WRAP)
          wave_q <= 1'b0;
      end
      else if (hit)
        wave_q <= ~wave_q;
    end
  end

  assign count_o = count_q;
  assign match_o = match_q;
  assign wave_o  = wave_q;

endmodule
`default_nettype wire

// *** dv/evt_timer_sva.sv ***
// Assertion checker for the timer channel top ports.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module evt_timer_sva
  import evt_timer_pkg::*;
(
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        reset_i,
  // Register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [3:0]  s_axi_awaddr,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // Pins
  input wire logic        wave_output_pin_o,
  input wire logic        match_irq_o
);
  // ----------
  // Properties
  // ----------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);
  // Address and data taken in one cycle
  logic wr_both;
  assign wr_both = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  AST_AW_REFUSE: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  AST_AR_REFUSE: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
  AST_B_ONE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  AST_R_ONE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data repeated");
  AST_R_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid && s_axi_rdata[31:8] == 24'h0) else $error("read answer late or wide");
  AST_W_ANSWER: assert property (wr_both |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  AST_QUIET: assert property ($fell(reset_i) |->
    !s_axi_bvalid && !s_axi_rvalid && !wave_output_pin_o && !match_irq_o)
    else $error("outputs active after reset");
  AST_STOP_LOW: assert property (wr_both && s_axi_awaddr == MODE_CTRL_OFFSET &&
    !s_axi_wdata[RUN_BIT] |-> ##[1:4] !wave_output_pin_o) else $error("stop left wave high");
endmodule
bind evt_timer evt_timer_sva evt_timer_sva_inst (.clk_i, .reset_i, .s_axi_awvalid,
  .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
  .wave_output_pin_o, .match_irq_o);
`default_nettype wire

// *** dv/evt_pin_partner.sv ***
// Far side model: event pulse source and load on the wave pin.
// Assumes the bench clock only paces pulses; the pin itself is async.
`timescale 1ns/1ps
`default_nettype none
module evt_pin_partner (
  // Pacing clock
  input  wire logic clk_i,
  // Pins
  input  wire logic wave_output_pin_i,
  output logic      event_input_pin_o
);
  // Idle low until a pulse is asked for
  initial
  begin
    event_input_pin_o = 1'b0;
  end
  // Drive a level and hold it long enough for the synchroniser
  task automatic set_level(input logic v, input int hold);
    @(posedge clk_i);
    event_input_pin_o <= v;
    repeat (hold) @(posedge clk_i);
  endtask
  // One full pulse, high then low, short or slow
  task automatic pulse(input int hi, input int lo);
    set_level(1'b1, hi);
    set_level(1'b0, lo);
  endtask
  // Load on the wave pin: count the rising edges it sees
  int   rise_cnt = 0;
  logic last_q   = 1'b0;
  always @(posedge clk_i)
  begin
    if (wave_output_pin_i && !last_q)
      rise_cnt++;
    last_q <= wave_output_pin_i;
  end
endmodule
`default_nettype wire

// *** dv/testbench.sv ***
// Self-checking bench for timer channel zero on the register bus.
// Assumes the partner model supplies event pulses.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import evt_timer_pkg::*;
  // -------
  // Signals
  // -------
  logic        clk_i = 1'b0, reset_i = 1'b1, sub_clock_i = 1'b0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = 32'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic        event_input_pin_i, wave_output_pin_o, match_irq_o;
  int          error_cnt = 0, checked = 0, cyc = 0, irqs = 0;
  evt_timer #(.CHANNEL(0)) evt_timer_inst (.clk_i, .reset_i, .s_axi_awvalid, .s_axi_awready,
    .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
    .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .event_input_pin_i, .sub_clock_i,
    .wave_output_pin_o, .match_irq_o);
  evt_pin_partner evt_pin_partner_inst (.clk_i, .wave_output_pin_i(wave_output_pin_o),
    .event_input_pin_o(event_input_pin_i));
  // Clock, cycle count and hang guard
  always #10 clk_i = ~clk_i;
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc > 20000)
    begin
      error_cnt++;
      $display("FAIL %0t timeout", $time);
      report_and_stop();
    end
  end
  // Count match pulses where they are settled
  always @(negedge clk_i)
    if (match_irq_o === 1'b1)
      irqs++;
  // --------------
  // Checks and bus
  // --------------
  task automatic tally(input logic ok, input string what);
    checked++;
    if (ok !== 1'b1)
    begin
      error_cnt++;
      $display("FAIL %0t %s", $time, what);
    end
  endtask
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    tally(got === exp, "value");
  endtask
  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    tally(got === exp, "bus response");
  endtask
  task automatic chk_time(input int got, input int exp);
    tally(got == exp, "cycle or pulse count");
  endtask
  task automatic report_and_stop();
    if (error_cnt == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Write one byte; sample handshakes where settled, act after the edge
  task automatic wr(input logic [3:0] a, input logic [7:0] d, output logic [1:0] r);
    logic ta, tw, tb;
    tb = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!tb)
    begin
      @(negedge clk_i);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge clk_i);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta, tr;
    tr = 1'b0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    while (!tr)
    begin
      @(negedge clk_i);
      ta = s_axi_arvalid && s_axi_arready;
      tr = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge clk_i);
      if (ta) s_axi_arvalid <= 1'b0;
    end
  endtask
  // Wait for a match pulse; note its cycle and the wave one cycle on
  task automatic wait_irq(output int t, output logic w);
    do
      @(negedge clk_i);
    while (match_irq_o !== 1'b1);
    t = cyc;
    @(negedge clk_i);
    w = wave_output_pin_o;
    @(posedge clk_i);
  endtask
  task automatic wave_is(input logic exp);
    @(negedge clk_i);
    chk_val({31'h0, wave_output_pin_o}, {31'h0, exp});
    @(posedge clk_i);
  endtask
  function automatic logic [7:0] mode(logic run, logic pwm, logic [1:0] sel, logic we);
    return {run, pwm, 3'b000, sel, we};
  endfunction
  function automatic int sq_period(int div, int n);
    return div * (n + 1);
  endfunction
  function automatic int pwm_high(int m);
    return 255 - m;
  endfunction
  // ---------
  // Sequence
  // ---------
  initial
  begin
    logic [1:0] r;
    logic [31:0] d;
    logic w0, w1;
    int n, k, t0, t1, hi;
    void'($urandom(32'h4541dab3));
    repeat (4) @(posedge clk_i);
    reset_i <= 1'b0;
    // Reset values, read-only and unmapped places
    rd(MODE_CTRL_OFFSET, d, r);
    chk_val(d, {24'h0, MODE_CTRL_RESET});
    rd(COMPARE_OFFSET, d, r);
    chk_val(d, {24'h0, COMPARE_RESET});
    wr(COUNT_OFFSET, 8'h5a, r);
    chk_resp(r, RESP_SLVERR);
    rd(4'h2, d, r);
    chk_resp(r, RESP_SLVERR);
    // Square wave on both internal taps
    for (int s = 0; s < 2; s++)
    begin
      n = $urandom_range(1, 6);
      wr(MODE_CTRL_OFFSET, mode(1'b0, 1'b0, 2'(s), 1'b1), r);
      wave_is(1'b0);
      wr(COMPARE_OFFSET, 8'(n), r);
      wr(MODE_CTRL_OFFSET, mode(1'b1, 1'b0, 2'(s), 1'b1), r);
      wave_is(1'b0);
      wait_irq(t0, w0);
      wait_irq(t1, w1);
      chk_time(t1 - t0, sq_period(s ? CH0_DIV_B : CH0_DIV_A, n));
      chk_val({30'h0, w0, w1}, 32'h2);
      wait_irq(t0, w0);
      wr(MODE_CTRL_OFFSET, mode(1'b0, 1'b0, 2'(s), 1'b1), r);
      wave_is(1'b0);
    end
    // Event counting on rising then falling edges
    for (int e = 0; e < 2; e++)
    begin
      n = $urandom_range(2, 5);
      wr(MODE_CTRL_OFFSET, mode(1'b0, 1'b0, {1'b1, 1'(e)}, 1'b0), r);
      wr(COMPARE_OFFSET, 8'(n), r);
      wr(MODE_CTRL_OFFSET, mode(1'b1, 1'b0, {1'b1, 1'(e)}, 1'b0), r);
      k = irqs;
      evt_pin_partner_inst.set_level(1'b1, 8);
      rd(COUNT_OFFSET, d, r);
      chk_val(d, e ? 32'h0 : 32'h1);
      evt_pin_partner_inst.set_level(1'b0, 8);
      rd(COUNT_OFFSET, d, r);
      chk_val(d, 32'h1);
      repeat (n - 1) evt_pin_partner_inst.pulse($urandom_range(4, 9), $urandom_range(4, 9));
      rd(COUNT_OFFSET, d, r);
      chk_val(d, 32'(n));
      evt_pin_partner_inst.pulse(5, 8);
      chk_time(irqs - k, 1);
      rd(COUNT_OFFSET, d, r);
      chk_val(d, 32'h0);
    end
    // Compare value zero matches every event
    wr(MODE_CTRL_OFFSET, mode(1'b0, 1'b0, 2'b10, 1'b0), r);
    wr(COMPARE_OFFSET, 8'h00, r);
    wr(MODE_CTRL_OFFSET, mode(1'b1, 1'b0, 2'b10, 1'b0), r);
    k = irqs;
    repeat (3) evt_pin_partner_inst.pulse(4, 6);
    chk_time(irqs - k, 3);
    // Sticky match flag is seen once, then cleared by its own read
    rd(STATUS_OFFSET, d, r);
    chk_val(d, 32'h1);
    rd(STATUS_OFFSET, d, r);
    chk_val(d, 32'h0);
    // Pulse width modulation
    n = $urandom_range(1, 250);
    wr(MODE_CTRL_OFFSET, mode(1'b0, 1'b1, 2'b00, 1'b1), r);
    wr(COMPARE_OFFSET, 8'(n), r);
    wr(MODE_CTRL_OFFSET, mode(1'b1, 1'b1, 2'b00, 1'b1), r);
    wait_irq(t0, w0);
    wait_irq(t1, w1);
    chk_time(t1 - t0, 256);
    chk_val({31'h0, w1}, 32'h1);
    hi = 0;
    @(negedge clk_i);
    k = evt_pin_partner_inst.rise_cnt;
    repeat (256) @(negedge clk_i) hi += int'(wave_output_pin_o);
    chk_time(evt_pin_partner_inst.rise_cnt - k, 1);
    @(posedge clk_i);
    chk_time(hi, pwm_high(n));
    report_and_stop();
  end
endmodule
`default_nettype wire
